// *** hdl/sepc_pkg.sv ***
package sepc_pkg;
    // instruction frame layout
    localparam int OPCODE_BITS   = 2;
    localparam int ADDR_BITS     = 6;
    localparam int WORD_ADDR_BITS = 4;
    localparam int DATA_BITS     = 16;
    localparam int WORDS         = 16;
    localparam int PROT_BITS     = 6;
    // opcodes
    localparam logic [1:0] OP_EXT   = 2'h0;
    localparam logic [1:0] OP_WRITE = 2'h1;
    localparam logic [1:0] OP_READ  = 2'h2;
    localparam logic [1:0] OP_CLEAR = 2'h3;
    // top address bits under the extended opcode
    localparam logic [1:0] EXT_WDS  = 2'h0;
    localparam logic [1:0] EXT_WRAL = 2'h1;
    localparam logic [1:0] EXT_LOCK = 2'h0;
    localparam logic [1:0] EXT_WEN  = 2'h3;
    // reset values
    localparam logic [PROT_BITS-1:0] PROT_RESET = 6'h3F;
    // timing, at the 250 MHz clock
    localparam int CLOCK_MHZ       = 250;
    localparam int DESELECT_NS     = 250;
    localparam int DESELECT_CYCLES = (DESELECT_NS * CLOCK_MHZ + 999) / 1000;
    localparam int PROG_MS         = 10;
    localparam int PROG_CYCLES     = PROG_MS * CLOCK_MHZ * 1000;
    localparam int MIN_BIT_COUNT   = 1;
    // command sequencer states
    typedef enum logic [2:0] {
        SEPC_IDLE,
        SEPC_OPCODE,
        SEPC_ADDR,
        SEPC_DATA,
        SEPC_OUT,
        SEPC_DONE
    } sepc_state_t;
endpackage : sepc_pkg

// *** hdl/sepc_port.sv ***
// Contract
// - sample input, launch output on serial_clock rise
// - drive output only while selected
// - protect_select picks array or protect register
// - writes refused while program_enable low
// - skip leading zeros, first one starts
// - two-bit opcode follows start bit
// - six address bits, low four select word
// - sixteen data bits, msb first both ways
// - opcode and top address decode instruction
// - select fall ends instruction, starts programming
// - read loads word, dummy zero, msb first
// - continued clocking streams next word in array reads
// - word pointer wraps last to first
// - dummy bit only before first word
// - write disabled after reset
// - write enable latch set at select fall
// - reads ignore write enable latch
// - word write needs enable, unprotected, pins
// - status on output while selected, busy zero
// - select rise resets sequencer, shifters
// - deselected pins ignored
`timescale 1ns/1ns
`default_nettype none
module sepc_port
    import sepc_pkg::*;
#(
    parameter int PROG_TIME_CYCLES = PROG_CYCLES
) (
    input  wire logic clock,
    input  wire logic reset_n,
    input  wire logic select,
    input  wire logic serial_clock,
    input  wire logic serial_in,
    input  wire logic protect_select,
    input  wire logic program_enable,
    output logic      serial_out,
    output logic      serial_out_en,
    output logic      busy
);
    // two-flop synchronisers for every pin
    logic [4:0] sync_a;
    logic [4:0] sync_b;
    always_ff @(posedge clock) begin
        sync_a <= {select, serial_clock, serial_in, protect_select, program_enable};
        sync_b <= sync_a;
    end
    // pin levels after the second flop
    wire cs_s  = sync_b[4];
    wire sk_s  = sync_b[3];
    wire di_s  = sync_b[2];
    wire pre_s = sync_b[1];
    wire pe_s  = sync_b[0];

    // edge history of synchronised select and clock
    logic cs_d;
    logic sk_d;
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            cs_d <= 1'b0;
            sk_d <= 1'b0;
        end else begin
            cs_d <= cs_s;
            sk_d <= sk_s;
        end
    end
    // edges of the synchronised select and serial clock
    wire cs_rise = cs_s && !cs_d;
    wire cs_fall = !cs_s && cs_d;
    wire sk_rise = cs_s && sk_s && !sk_d;

    // storage and state
    logic [DATA_BITS-1:0]      mem [WORDS];
    logic [PROT_BITS-1:0]      prot;
    logic                      prot_locked;
    logic                      prot_unlocked;
    logic                      wen_latch;

    // sequencer and received fields
    sepc_state_t               state;
    logic [4:0]                count;
    logic [OPCODE_BITS-1:0]    opcode;
    logic [ADDR_BITS-1:0]      addr;
    logic [DATA_BITS-1:0]      data_sr;

    // read path
    logic [DATA_BITS-1:0]      out_sr;
    logic [WORD_ADDR_BITS-1:0] ptr;
    logic                      inst_pre;
    logic                      inst_pe;
    logic                      out_bit;

    // programming timer and deselect interval
    logic [31:0]               prog_count;
    logic [DESELECT_CYCLES:0]  low_count;
    logic                      deselect_ok;

    // extended opcode with a given pair of top address bits
    function automatic logic ext_match(input logic [1:0] op, input logic [1:0] hi,
                                       input logic [1:0] want);
        return op == OP_EXT && hi == want;
    endfunction : ext_match

    // word pointer step, wrapping from the last word to the first
    function automatic logic [WORD_ADDR_BITS-1:0] next_ptr(input logic [WORD_ADDR_BITS-1:0] p);
        return p + 1'b1;
    endfunction : next_ptr

    // instruction decode
    wire [1:0] top2     = addr[5:4];
    wire [3:0] word     = addr[3:0];
    // array instructions
    wire       ar_read  = !inst_pre && opcode == OP_READ;
    wire       ar_write = !inst_pre && opcode == OP_WRITE;
    wire       ar_wral  = !inst_pre && ext_match(opcode, top2, EXT_WRAL);
    wire       ar_wen   = !inst_pre && ext_match(opcode, top2, EXT_WEN);
    wire       ar_wds   = !inst_pre && ext_match(opcode, top2, EXT_WDS);
    // protect register instructions
    wire       pr_read  = inst_pre && opcode == OP_READ;
    wire       pr_en    = inst_pre && ext_match(opcode, top2, EXT_WEN);
    wire       pr_clear = inst_pre && opcode == OP_CLEAR;
    wire       pr_write = inst_pre && opcode == OP_WRITE;
    wire       pr_lock  = inst_pre && ext_match(opcode, top2, EXT_LOCK);
    wire       needs_data = ar_write || ar_wral;
    wire       any_read   = ar_read || pr_read;
    // write-all head: top bits sit one place lower as the last address bit arrives
    wire       wral_head  = !inst_pre && ext_match(opcode, addr[4:3], EXT_WRAL);

    // enabling conditions, checked when select falls
    wire       base_ok   = wen_latch && inst_pe && !busy;
    wire       ok_write  = base_ok && ar_write && {2'h0, word} < prot;
    wire       ok_wral   = base_ok && ar_wral && prot == PROT_RESET;
    wire       ok_protect_unlock_cmd   = base_ok && pr_en && !prot_locked;
    // protect register changes need the unlock from the frame before
    wire       pr_gate   = base_ok && prot_unlocked && !prot_locked;
    wire       ok_clear  = pr_gate && pr_clear;
    wire       ok_pwrite = pr_gate && pr_write && prot == PROT_RESET;
    wire       ok_lock   = pr_gate && pr_lock;
    wire       done      = state == SEPC_DONE;
    wire       starts_prog = done && (ok_write || ok_wral || ok_clear
                                      || ok_pwrite || ok_lock);

    // deselect interval timer; deselect_ok once select stayed low long enough
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            low_count   <= '0;
            deselect_ok <= 1'b1;
        end else if (cs_s) begin
            low_count   <= '0;
            deselect_ok <= 1'b0;
        end else if (low_count < (DESELECT_CYCLES + 1)'(DESELECT_CYCLES)) begin
            low_count   <= low_count + 1'b1;
        end else begin
            deselect_ok <= 1'b1;
        end
    end

    // command sequencer
    always_ff @(posedge clock) begin
        if (!reset_n || cs_rise) begin
            state   <= SEPC_IDLE;
            count   <= '0;
        end else if (cs_fall) begin
            state   <= SEPC_IDLE;
        end else if (sk_rise) begin
            case (state)
                // wait for the start bit
                SEPC_IDLE: begin
                    if (di_s) begin
                        state <= SEPC_OPCODE;
                        count <= '0;
                    end
                end
                // two opcode bits
                SEPC_OPCODE: begin
                    count <= count + 1'b1;
                    if (count == 5'(OPCODE_BITS - 1)) begin
                        state <= SEPC_ADDR;
                        count <= '0;
                    end
                end
                // six address bits, then data, read or done
                SEPC_ADDR: begin
                    count <= count + 1'b1;
                    if (count == 5'(ADDR_BITS - 1)) begin
                        count <= '0;
                        state <= SEPC_DONE;
                        if (opcode == OP_READ) begin
                            state <= SEPC_OUT;
                        end else if (opcode == OP_WRITE && !inst_pre) begin
                            state <= SEPC_DATA;
                        end else if (wral_head) begin
                            state <= SEPC_DATA;         // top bits 01 mean write-all
                        end
                    end
                end
                // sixteen data bits
                SEPC_DATA: begin
                    count <= count + 1'b1;
                    if (count == 5'(DATA_BITS - 1)) begin
                        state <= SEPC_DONE;
                    end
                end
                // read data streaming
                SEPC_OUT: begin
                    count <= count + 1'b1;
                end
                // hold until select falls
                SEPC_DONE: begin
                    state <= SEPC_DONE;
                end
                default: begin
                    state <= SEPC_IDLE;
                end
            endcase
        end
    end

    // field shift registers, pins captured at the start bit
    always_ff @(posedge clock) begin
        if (!reset_n || cs_rise || deselect_ok) begin
            opcode   <= '0;
            addr     <= '0;
            data_sr  <= '0;
            inst_pre <= 1'b0;
            inst_pe  <= 1'b0;
        end else if (sk_rise) begin
            // pin levels are frozen for the whole instruction
            if (state == SEPC_IDLE && di_s) begin
                inst_pre <= pre_s;
                inst_pe  <= pe_s;
            end
            if (state == SEPC_OPCODE) begin
                opcode <= {opcode[0], di_s};
            end
            if (state == SEPC_ADDR) begin
                addr <= {addr[ADDR_BITS-2:0], di_s};
            end
            if (state == SEPC_DATA) begin
                data_sr <= {data_sr[DATA_BITS-2:0], di_s};
            end
        end
    end

    // read output path: dummy zero, then words msb first, wrapping
    wire last_addr = state == SEPC_ADDR && count == 5'(ADDR_BITS - 1);
    wire [3:0] first_word = {word[2:0], di_s};
    wire word_end = state == SEPC_OUT && count[3:0] == 4'hF;
    wire [WORD_ADDR_BITS-1:0] step_ptr = next_ptr(ptr);
    wire [DATA_BITS-1:0] prot_word = {prot, 10'h000};   // six bits, msb first, then zeros
    always_ff @(posedge clock) begin
        if (!reset_n || cs_rise || deselect_ok) begin
            out_sr  <= '0;
            ptr     <= '0;
            out_bit <= 1'b0;
        end else if (sk_rise) begin
            // last address bit: load the word and show the dummy zero
            if (last_addr && opcode == OP_READ) begin
                ptr     <= first_word;
                out_sr  <= inst_pre ? prot_word : mem[first_word];
                out_bit <= 1'b0;
            end else if (state == SEPC_OUT) begin
                out_bit <= out_sr[DATA_BITS-1];
                if (word_end && ar_read) begin
                    ptr    <= step_ptr;
                    out_sr <= mem[step_ptr];
                end else begin
                    out_sr <= {out_sr[DATA_BITS-2:0], 1'b0};
                end
            end
        end
    end

    // array, protect register and latches, updated when select falls
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            wen_latch     <= 1'b0;
            prot          <= PROT_RESET;
            prot_locked   <= 1'b0;
            prot_unlocked <= 1'b0;
        end else if (cs_fall && (done || state == SEPC_OUT)) begin
            // the unlock lasts for the next frame only
            prot_unlocked <= ok_protect_unlock_cmd;
            if (ar_wen && done) begin
                wen_latch <= 1'b1;
            end
            if (ar_wds && done) begin
                wen_latch <= 1'b0;
            end
            if (ok_write && done) begin
                mem[word] <= data_sr;
            end
            if (ok_wral && done) begin
                for (int i = 0; i < WORDS; i++) begin
                    mem[i] <= data_sr;
                end
            end
            if (ok_clear && done) begin
                prot <= PROT_RESET;
            end
            if (ok_pwrite && done) begin
                prot <= addr;
            end
            if (ok_lock && done) begin
                prot_locked <= 1'b1;
            end
        end
    end

    // last cycle of the programming count
    wire prog_last = prog_count == 32'h0;

    // self-timed programming cycle
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            busy       <= 1'b0;
            prog_count <= '0;
        end else if (cs_fall && starts_prog) begin
            busy       <= 1'b1;
            prog_count <= 32'(PROG_TIME_CYCLES - 1);
        end else if (busy) begin
            prog_count <= prog_count - 1'b1;
            busy       <= !prog_last;
        end
    end

    // output pin: read data while streaming a read, status otherwise
    wire show_data = state == SEPC_OUT;
    wire status_bit = !busy;                            // ready high, busy low
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            serial_out    <= 1'b0;
            serial_out_en <= 1'b0;
        end else begin
            // enable follows select one cycle after the synchroniser
            serial_out_en <= cs_s;
            serial_out    <= show_data ? out_bit : status_bit;
        end
    end
endmodule : sepc_port
`default_nettype wire

// *** tb/sepc_port_assertions.sv ***
`timescale 1ns/1ns
`default_nettype none
module sepc_port_assertions #(
    parameter int PROG_TIME_CYCLES = 400
) (
    input wire logic clock,
    input wire logic reset_n,
    input wire logic select,
    input wire logic serial_clock,
    input wire logic serial_in,
    input wire logic protect_select,
    input wire logic program_enable,
    input wire logic serial_out,
    input wire logic serial_out_en,
    input wire logic busy
);
    int busy_len;
    // length of the current busy period
    always_ff @(posedge clock) begin
        if (!reset_n || !busy) busy_len <= 0;
        else busy_len <= busy_len + 1;
    end
    default clocking @(posedge clock); endclocking
    default disable iff (!reset_n);
    // output enable follows select after synchronising
    a_en_off_desel: assert property ((!select)[*5] |-> !serial_out_en)
        else $error("output enabled while deselected");
    a_en_on_sel: assert property ((select && reset_n)[*5] |-> serial_out_en)
        else $error("output not enabled while selected");
    a_en_rise_sel: assert property ($rose(serial_out_en) |-> select)
        else $error("output enable rose without select");
    // programming cycle starts only from a deselect
    a_busy_on_fall: assert property ($rose(busy) |-> !select)
        else $error("busy started while selected");
    a_busy_needs_pe: assert property ($rose(busy) |-> $past(program_enable, 4))
        else $error("busy started with program enable low");
    a_busy_length: assert property ($fell(busy) |-> busy_len >= PROG_TIME_CYCLES - 1
        && busy_len <= PROG_TIME_CYCLES + 1)
        else $error("programming time wrong");
    // status seen on serial output while polling
    a_status_busy: assert property (busy && $past(busy, 8) && serial_out_en
        && $past(serial_out_en, 8) |-> !serial_out)
        else $error("status not low while busy");
    a_status_ready: assert property ($fell(busy) && serial_out_en |-> ##[0:3] serial_out)
        else $error("status not high once ready");
    cover property ($rose(busy));
    cover property ($fell(busy) && serial_out_en);
    cover property ($rose(serial_out_en));
endmodule : sepc_port_assertions
bind sepc_port sepc_port_assertions #(.PROG_TIME_CYCLES(PROG_TIME_CYCLES)) chk (
    .clock(clock), .reset_n(reset_n), .select(select), .serial_clock(serial_clock),
    .serial_in(serial_in), .protect_select(protect_select), .program_enable(program_enable),
    .serial_out(serial_out), .serial_out_en(serial_out_en), .busy(busy));
`default_nettype wire

// *** tb/sepc_master.sv ***
`timescale 1ns/1ns
`default_nettype none
module sepc_master (
    input  wire logic clock,
    input  wire logic serial_out,
    output logic      select,
    output logic      serial_clock,
    output logic      serial_in
);
    initial begin
        select = 1'b0;
        serial_clock = 1'b0;
        serial_in = 1'b0;
    end
    // one serial clock period, returns the output seen before the rise
    task automatic xfer(input logic b, output logic got);
        serial_in <= b;
        repeat (20) @(posedge clock);
        got = serial_out;
        serial_clock <= 1'b1;
        repeat (20) @(posedge clock);
        serial_clock <= 1'b0;
    endtask : xfer
    task automatic open_frame;
        @(posedge clock);
        select <= 1'b1;
        repeat (13) @(posedge clock);
    endtask : open_frame
    // drop select before the next rise, then keep it low long enough
    task automatic close_frame;
        select <= 1'b0;
        serial_in <= ~serial_in;
        repeat (70) @(posedge clock);
    endtask : close_frame
    // start bit, opcode and all six address bits
    task automatic head(input int zeros, input logic [1:0] op, input logic [5:0] addr,
                        output logic last);
        logic [8:0] f;
        f = {1'b1, op, addr};
        repeat (zeros) xfer(1'b0, last);
        for (int i = 8; i >= 0; i--) xfer(f[i], last);
    endtask : head
    task automatic word(input logic [15:0] d, output logic [15:0] q);
        for (int i = 15; i >= 0; i--) xfer(d[i], q[i]);
    endtask : word
endmodule : sepc_master
`default_nettype wire

// *** tb/tb.sv ***
`timescale 1ns/1ns
`default_nettype none
module tb;
    import sepc_pkg::*;
    logic        clock, reset_n, protect_select, program_enable;
    logic        select, serial_clock, serial_in, serial_out, serial_out_en, busy;
    logic [15:0] mem [16];
    int          bad_count, total_checks;
    sepc_port #(.PROG_TIME_CYCLES(400)) DUT (.clock(clock), .reset_n(reset_n),
        .select(select), .serial_clock(serial_clock), .serial_in(serial_in),
        .protect_select(protect_select), .program_enable(program_enable),
        .serial_out(serial_out), .serial_out_en(serial_out_en), .busy(busy));
    sepc_master p (.clock(clock), .serial_out(serial_out), .select(select),
        .serial_clock(serial_clock), .serial_in(serial_in));
    initial begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        total_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic final_report;
        if (bad_count == 0 && total_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : final_report
    // reselect during programming and watch the status
    task automatic poll;
        int n;
        p.open_frame();
        chk({15'h0000, serial_out_en}, 16'h0001);
        chk({15'h0000, serial_out}, 16'h0000);
        n = 0;
        while (serial_out !== 1'b1 && n < 600) begin
            @(posedge clock);
            n++;
        end
        chk({15'h0000, serial_out}, 16'h0001);
        p.close_frame();
        chk({15'h0000, serial_out_en}, 16'h0000);
    endtask : poll
    task automatic cmd(input logic [1:0] op, input logic [5:0] addr);
        logic x;
        p.open_frame();
        p.head(0, op, addr, x);
        p.close_frame();
    endtask : cmd
    task automatic wr(input logic [3:0] a, input logic [15:0] d, input logic exp_busy);
        logic        x;
        logic [15:0] q;
        p.open_frame();
        p.head(0, OP_WRITE, {2'b10, a}, x);
        p.word(d, q);
        p.close_frame();
        chk({15'h0000, busy}, {15'h0000, exp_busy});
        if (exp_busy) poll();
    endtask : wr
    task automatic rd(input logic [3:0] a, input int n);
        logic        x;
        logic [15:0] q;
        p.open_frame();
        p.head(2, OP_READ, {2'b11, a}, x);
        p.xfer(1'b0, x);
        chk({15'h0000, x}, 16'h0000);
        for (int i = 0; i < n; i++) begin
            p.word(16'h0000, q);
            chk(q, mem[4'(a + i)]);
        end
        p.close_frame();
    endtask : rd
    task automatic t_fill;
        wr(4'h3, 16'h1234, 1'b0);
        cmd(OP_EXT, {EXT_WEN, 4'h0});
        for (int i = 0; i < 16; i++) begin
            mem[i] = {i[3:0], ~i[3:0], 8'hA5};
            wr(4'(i), mem[i], 1'b1);
        end
    endtask : t_fill
    task automatic t_refused;
        @(posedge clock);
        program_enable <= 1'b0;
        wr(4'h5, 16'hFFFF, 1'b0);
        program_enable <= 1'b1;
        protect_select <= 1'b1;
        wr(4'h6, 16'h0000, 1'b0);
        protect_select <= 1'b0;
        rd(4'h5, 2);
    endtask : t_refused
    // serial clocking while deselected must not write
    task automatic t_desel;
        logic        x;
        logic [15:0] q;
        p.head(0, OP_WRITE, 6'h07, x);
        p.word(16'h0000, q);
        repeat (70) @(posedge clock);
        chk({15'h0000, busy}, 16'h0000);
        rd(4'h7, 1);
    endtask : t_desel
    // one word written to the whole array, then read back in one stream
    task automatic t_wral;
        logic        x;
        logic [15:0] q;
        p.open_frame();
        p.head(0, OP_EXT, {EXT_WRAL, 4'h0}, x);
        p.word(16'h5A3C, q);
        p.close_frame();
        chk({15'h0000, busy}, 16'h0001);
        poll();
        for (int i = 0; i < 16; i++) mem[i] = 16'h5A3C;
        rd(4'h0, 16);
    endtask : t_wral
    task automatic t_wds;
        cmd(OP_EXT, {EXT_WDS, 4'h0});
        wr(4'h8, 16'h0000, 1'b0);
        rd(4'h8, 1);
    endtask : t_wds
    initial begin
        reset_n = 1'b0;
        protect_select = 1'b0;
        program_enable = 1'b1;
        repeat (5) @(posedge clock);
        reset_n <= 1'b1;
        repeat (5) @(posedge clock);
        t_fill();
        t_refused();
        rd(4'hE, 4);
        t_desel();
        t_wral();
        t_wds();
        final_report();
    end
    initial begin
        #360000;
        bad_count++;
        $display("wrong value at %0t: timeout", $time);
        final_report();
    end
endmodule : tb
`default_nettype wire
